/* File: include/hbd_pkg.sv */
// Purpose: shared constants and types of the winding decay selector
// Assumes: one full bridge per winding, four gate outputs
// Notes: register offsets are byte addresses on the plain register port
package hbd_pkg;

  // decay pattern codes, shared by both selectors and the status view
  typedef enum logic [2:0] {
    HBD_FAST         = 3'h0,
    HBD_REVERSE      = 3'h1,
    HBD_SLOW_L_DIODE = 3'h2,
    HBD_SLOW_H_DIODE = 3'h3,
    HBD_SLOW_L_FET   = 3'h4,
    HBD_SLOW_H_FET   = 3'h5
  } hbd_mode_t;

  typedef enum logic [0:0] {
    HBD_POL_FIXED     = 1'h0,
    HBD_POL_ALTERNATE = 1'h1
  } hbd_policy_t;

  localparam int HBD_ADDR_W = 6;
  localparam int HBD_DATA_W = 32;
  localparam int HBD_MODE_W = 3;
  localparam int HBD_GAIN_W = 8;

  // register map
  localparam logic [HBD_ADDR_W-1:0] HBD_REG_POLICY = 6'h00;
  localparam logic [HBD_ADDR_W-1:0] HBD_REG_PRIMARY = 6'h04;
  localparam logic [HBD_ADDR_W-1:0] HBD_REG_SECONDARY = 6'h08;
  localparam logic [HBD_ADDR_W-1:0] HBD_REG_GAIN = 6'h0c;
  localparam logic [HBD_ADDR_W-1:0] HBD_REG_STATUS = 6'h10;
  localparam logic [HBD_ADDR_W-1:0] HBD_REG_REMAIN = 6'h14;

  // status field positions
  localparam int HBD_ST_MODE_LSB = 0;
  localparam int HBD_ST_ALT_BIT = 4;
  localparam int HBD_ST_SLOW_BIT = 5;
  localparam int HBD_ST_POL_BIT = 6;

  // reset values
  localparam hbd_policy_t HBD_RST_POLICY = HBD_POL_FIXED;
  localparam hbd_mode_t HBD_RST_PRIMARY = HBD_SLOW_L_FET;
  localparam hbd_mode_t HBD_RST_SECONDARY = HBD_FAST;
  localparam logic [HBD_GAIN_W-1:0] HBD_RST_GAIN = 8'h10;

endpackage : hbd_pkg

/* File: core/hbd_decay_selector.sv */
// Purpose: map the chosen decay pattern onto the four gate drives of one winding
// Assumes: PWM_IN, PERIOD_START, target and shunt inputs come from logic on MCLK
// Notes: no dead time is inserted here; the gate drivers must supply it
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ns

// Operation
// - reverse decay drives all four gates from the pwm waveform, none held constant.
// - slow decay with low fet recirculation drives high-a and low-a from pwm, high-b at 1, low-b at 0.
// - both selectors accept the fast diode option and the reverse fet option.
// - both selectors accept the four slow options: low diode, high diode, both low fets, both high fets.
// - every slow pattern keeps one drive transistor on continuously so the winding is shorted.
// - shunt samples are marked unavailable while a slow pattern is recirculating.
// - with the fixed policy only the primary selection is applied in every decay interval.
// - with the alternate policy decay intervals switch between the primary and secondary selections.
// - the secondary pattern is used only after a falling target and only until the current reaches it.
// - the number of secondary periods at a step is proportional to the drop of the target.
// - with the alternate policy, while the target is zero the winding is held in fast decay.
// - shunt current is positive while energising and negative during fast decay.
// - plain fast decay drives both high gates from pwm and holds both low gates at 0.
module hbd_decay_selector
  import hbd_pkg::*;
#(
  parameter int TGT_W = 12,
  parameter int CNT_W = 16,
  parameter int DROP_SHIFT = 4
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PWM_IN,
  input wire logic PERIOD_START,
  input wire logic [TGT_W-1:0] TARGET_CURRENT,
  input wire logic TARGET_STROBE,
  input wire logic [TGT_W-1:0] SHUNT_SAMPLE,
  input wire logic SHUNT_VALID,
  input wire logic [HBD_ADDR_W-1:0] ADDR,
  input wire logic [HBD_DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [HBD_DATA_W-1:0] RDATA,
  output logic GATE_HIGH_A,
  output logic GATE_LOW_A,
  output logic GATE_HIGH_B,
  output logic GATE_LOW_B,
  output logic [TGT_W:0] CURRENT_SIGNED,
  output logic CURRENT_VALID
);

  localparam int PW = TGT_W + HBD_GAIN_W;

  generate
    if (TGT_W < 4 || TGT_W > 16) begin : g_bad_tgt
      $error("TGT_W out of range 4..16");
    end
    if (CNT_W < 1 || CNT_W > PW) begin : g_bad_cnt
      $error("CNT_W must lie in 1..TGT_W+8");
    end
    if (DROP_SHIFT < 0 || DROP_SHIFT >= PW) begin : g_bad_shift
      $error("DROP_SHIFT out of range");
    end
  endgenerate

  // reset release through two flops
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // software-visible selections, staged until the next period boundary; drop_gain acts from the next falling step
  hbd_policy_t policy_sel;
  hbd_mode_t primary_decay_select;
  hbd_mode_t secondary_decay_select;
  logic [HBD_GAIN_W-1:0] drop_gain;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      policy_sel <= HBD_RST_POLICY;
      primary_decay_select <= HBD_RST_PRIMARY;
      secondary_decay_select <= HBD_RST_SECONDARY;
      drop_gain <= HBD_RST_GAIN;
    end else if (WR) begin
      case (ADDR)
        HBD_REG_POLICY: begin
          policy_sel <= hbd_policy_t'(WDATA[0]);
        end
        HBD_REG_PRIMARY: begin
          primary_decay_select <= hbd_mode_t'(WDATA[HBD_MODE_W-1:0]);
        end
        HBD_REG_SECONDARY: begin
          secondary_decay_select <= hbd_mode_t'(WDATA[HBD_MODE_W-1:0]);
        end
        HBD_REG_GAIN: begin
          drop_gain <= WDATA[HBD_GAIN_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // policy as applied in the current period; the mode itself is latched into mode_now
  hbd_policy_t decay_policy_select;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      decay_policy_select <= HBD_RST_POLICY;
    end else if (PERIOD_START) begin
      decay_policy_select <= policy_sel;
    end
  end

  // last measured winding current magnitude
  logic [TGT_W-1:0] current_mag;
  logic sample_ok;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      current_mag <= '0;
    end else if (SHUNT_VALID && sample_ok) begin
      current_mag <= SHUNT_SAMPLE;
    end
  end

  // secondary period budget, loaded from the target drop at each falling step
  logic [TGT_W-1:0] target_prev;
  logic [CNT_W-1:0] alt_remain;
  logic [PW-1:0] drop_product;
  logic [PW-1:0] drop_scaled;
  logic [CNT_W-1:0] alt_load;
  logic target_fall;

  always_comb begin
    target_fall = TARGET_STROBE && (TARGET_CURRENT < target_prev);
    drop_product = PW'(target_prev - TARGET_CURRENT) * PW'(drop_gain);
    drop_scaled = drop_product >> DROP_SHIFT;
    if (drop_scaled > PW'({CNT_W{1'b1}})) begin
      alt_load = {CNT_W{1'b1}};
    end else begin
      alt_load = drop_scaled[CNT_W-1:0];
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      target_prev <= '0;
    end else if (TARGET_STROBE) begin
      target_prev <= TARGET_CURRENT;
    end
  end

  logic reached;
  assign reached = current_mag <= TARGET_CURRENT;

  // a new falling step wins over the period decrement in the same cycle
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      alt_remain <= '0;
    end else if (target_fall) begin
      alt_remain <= alt_load;
    end else if (PERIOD_START && alt_remain != '0) begin
      if (reached) begin
        alt_remain <= '0;
      end else begin
        alt_remain <= alt_remain - CNT_W'(1);
      end
    end
  end

  // pattern applied for the whole coming period
  hbd_mode_t mode_now;
  logic alt_active;
  hbd_mode_t next_mode;
  logic next_alt;

  always_comb begin
    next_mode = primary_decay_select;
    next_alt = 1'b0;
    if (policy_sel == HBD_POL_FIXED) begin
      next_mode = primary_decay_select;
    end else if (TARGET_CURRENT == '0) begin
      next_mode = HBD_FAST;
    end else if (alt_remain != '0 && !reached) begin
      next_mode = secondary_decay_select;
      next_alt = 1'b1;
    end else begin
      next_mode = primary_decay_select;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_now <= HBD_RST_PRIMARY;
      alt_active <= 1'b0;
    end else if (PERIOD_START) begin
      mode_now <= next_mode;
      alt_active <= next_alt;
    end
  end

  // gate pattern from the pwm level; unknown codes fall back to low fet slow
  logic next_ha;
  logic next_la;
  logic next_hb;
  logic next_lb;
  logic slow_mode;
  logic fast_mode;

  always_comb begin
    slow_mode = 1'b1;
    fast_mode = 1'b0;
    next_ha = PWM_IN;
    next_la = ~PWM_IN;
    next_hb = 1'b1;
    next_lb = 1'b0;
    case (mode_now)
      HBD_FAST: begin
        slow_mode = 1'b0;
        fast_mode = 1'b1;
        next_ha = PWM_IN;
        next_la = 1'b0;
        next_hb = PWM_IN;
        next_lb = 1'b0;
      end
      HBD_REVERSE: begin
        slow_mode = 1'b0;
        fast_mode = 1'b1;
        next_ha = PWM_IN;
        next_la = ~PWM_IN;
        next_hb = PWM_IN;
        next_lb = ~PWM_IN;
      end
      HBD_SLOW_L_DIODE: begin
        next_ha = PWM_IN;
        next_la = 1'b0;
        next_hb = 1'b1;
        next_lb = 1'b0;
      end
      HBD_SLOW_H_DIODE: begin
        next_ha = 1'b1;
        next_la = 1'b0;
        next_hb = PWM_IN;
        next_lb = 1'b0;
      end
      HBD_SLOW_H_FET: begin
        next_ha = 1'b1;
        next_la = 1'b0;
        next_hb = PWM_IN;
        next_lb = ~PWM_IN;
      end
      default: begin
        next_ha = PWM_IN;
        next_la = ~PWM_IN;
        next_hb = 1'b1;
        next_lb = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      GATE_HIGH_A <= 1'b0;
      GATE_LOW_A <= 1'b0;
      GATE_HIGH_B <= 1'b0;
      GATE_LOW_B <= 1'b0;
    end else begin
      GATE_HIGH_A <= next_ha;
      GATE_LOW_A <= next_la;
      GATE_HIGH_B <= next_hb;
      GATE_LOW_B <= next_lb;
    end
  end

  // recirculating current bypasses the shunt, so off-phase slow samples are dropped
  assign sample_ok = PWM_IN || !slow_mode;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      CURRENT_SIGNED <= '0;
      CURRENT_VALID <= 1'b0;
    end else begin
      CURRENT_VALID <= SHUNT_VALID && sample_ok;
      if (SHUNT_VALID && sample_ok) begin
        if (PWM_IN) begin
          CURRENT_SIGNED <= {1'b0, SHUNT_SAMPLE};
        end else if (fast_mode) begin
          CURRENT_SIGNED <= -{1'b0, SHUNT_SAMPLE};
        end
      end
    end
  end

  // register read port, data one cycle after the strobe
  logic [HBD_DATA_W-1:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    case (ADDR)
      HBD_REG_POLICY: begin
        next_rdata[0] = policy_sel;
      end
      HBD_REG_PRIMARY: begin
        next_rdata[HBD_MODE_W-1:0] = primary_decay_select;
      end
      HBD_REG_SECONDARY: begin
        next_rdata[HBD_MODE_W-1:0] = secondary_decay_select;
      end
      HBD_REG_GAIN: begin
        next_rdata[HBD_GAIN_W-1:0] = drop_gain;
      end
      HBD_REG_STATUS: begin
        next_rdata[HBD_ST_MODE_LSB +: HBD_MODE_W] = mode_now;
        next_rdata[HBD_ST_ALT_BIT] = alt_active;
        next_rdata[HBD_ST_SLOW_BIT] = slow_mode;
        next_rdata[HBD_ST_POL_BIT] = decay_policy_select;
      end
      HBD_REG_REMAIN: begin
        next_rdata[CNT_W-1:0] = alt_remain;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= '0;
    end else if (RD) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= '0;
    end
  end

endmodule : hbd_decay_selector

/* File: bench/hbd_decay_selector_assertions.sv */
// Purpose: port-level checks of the winding decay selector
// Assumes: registers are written only while no pwm period is running
// Notes: applied mode is tracked only where the ports decide it
`timescale 1ns/1ns
module hbd_chk
  import hbd_pkg::*;
#(
  parameter int TGT_W = 12
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PWM_IN,
  input wire logic PERIOD_START,
  input wire logic [TGT_W-1:0] TARGET_CURRENT,
  input wire logic [TGT_W-1:0] SHUNT_SAMPLE,
  input wire logic SHUNT_VALID,
  input wire logic [HBD_ADDR_W-1:0] ADDR,
  input wire logic [HBD_DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic GATE_HIGH_A,
  input wire logic GATE_LOW_A,
  input wire logic GATE_HIGH_B,
  input wire logic GATE_LOW_B,
  input wire logic [TGT_W:0] CURRENT_SIGNED,
  input wire logic CURRENT_VALID
);
  logic [3:0] rs;
  logic pol;
  logic known;
  logic [2:0] pri;
  logic [2:0] md;
  wire [3:0] g = {GATE_HIGH_A, GATE_LOW_A, GATE_HIGH_B, GATE_LOW_B};
  function automatic logic [3:0] pat(logic [2:0] m, logic p);
    case (m)
      3'h0: return {p, 1'b0, p, 1'b0};
      3'h1: return {p, ~p, p, ~p};
      3'h2: return {p, 1'b0, 1'b1, 1'b0};
      3'h3: return {1'b1, 1'b0, p, 1'b0};
      3'h5: return {1'b1, 1'b0, p, ~p};
      default: return {p, ~p, 1'b1, 1'b0};
    endcase
  endfunction : pat
  // released later than the design so its own sync stages have passed
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) rs <= 4'h0;
    else rs <= {rs[2:0], 1'b1};
  end
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) pol <= 1'b0;
    else if (WR && ADDR == HBD_REG_POLICY) pol <= WDATA[0];
  end
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) pri <= HBD_RST_PRIMARY;
    else if (WR && ADDR == HBD_REG_PRIMARY) pri <= WDATA[2:0];
  end
  // alternate with a nonzero target depends on internal current state
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      md <= HBD_RST_PRIMARY;
      known <= 1'b1;
    end else if (PERIOD_START) begin
      known <= !pol || TARGET_CURRENT == '0;
      md <= pol ? HBD_FAST : pri;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!rs[3]);
  // the applied mode moves one edge after the boundary pulse
  sequence s_quiet;
    !$past(PERIOD_START) && $stable(PWM_IN);
  endsequence
  sequence s_dark;
    SHUNT_VALID && !PWM_IN && known && md >= 3'h2;
  endsequence
  property p_pattern;
    known |=> g == pat($past(md), $past(PWM_IN));
  endproperty
  property p_reverse;
    known && md == 3'h1 |=> g == ({4{$past(PWM_IN)}} ^ 4'h5);
  endproperty
  property p_slow_lfet;
    known && md == 3'h4 |=> g == {$past(PWM_IN), ~$past(PWM_IN), 2'b10};
  endproperty
  property p_fast;
    known && md == 3'h0 |=> g == {$past(PWM_IN), 1'b0, $past(PWM_IN), 1'b0};
  endproperty
  property p_slow_on;
    known && md >= 3'h2 |=> GATE_HIGH_A || GATE_HIGH_B;
  endproperty
  property p_hold;
    s_quiet |=> $stable(g);
  endproperty
  property p_dark;
    s_dark |=> !CURRENT_VALID [*2];
  endproperty
  property p_sign;
    SHUNT_VALID && PWM_IN |=>
      CURRENT_VALID && CURRENT_SIGNED == {1'b0, $past(SHUNT_SAMPLE)};
  endproperty
  property p_sign_neg;
    SHUNT_VALID && !PWM_IN && known && md <= 3'h1 |=>
      CURRENT_VALID && CURRENT_SIGNED == -{1'b0, $past(SHUNT_SAMPLE)};
  endproperty
  a_pattern: assert property (p_pattern) else $error("gate pattern wrong");
  a_reverse: assert property (p_reverse) else $error("reverse gates wrong");
  a_slow_lfet: assert property (p_slow_lfet) else $error("slow fet gates wrong");
  a_fast: assert property (p_fast) else $error("fast gates wrong");
  a_slow_on: assert property (p_slow_on) else $error("no high gate held");
  a_hold: assert property (p_hold) else $error("pattern changed mid period");
  a_dark: assert property (p_dark) else $error("slow sample used");
  a_sign: assert property (p_sign) else $error("signed current wrong");
  a_sign_neg: assert property (p_sign_neg) else $error("decay current sign wrong");
endmodule : hbd_chk

bind hbd_decay_selector hbd_chk #(.TGT_W(TGT_W)) hbd_chk_inst (
  .MCLK(MCLK), .RST_N(RST_N), .PWM_IN(PWM_IN), .PERIOD_START(PERIOD_START),
  .TARGET_CURRENT(TARGET_CURRENT), .SHUNT_SAMPLE(SHUNT_SAMPLE),
  .SHUNT_VALID(SHUNT_VALID), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .GATE_HIGH_A(GATE_HIGH_A), .GATE_LOW_A(GATE_LOW_A), .GATE_HIGH_B(GATE_HIGH_B),
  .GATE_LOW_B(GATE_LOW_B), .CURRENT_SIGNED(CURRENT_SIGNED), .CURRENT_VALID(CURRENT_VALID));

/* File: bench/hbd_bridge_model.sv */
// Purpose: behavioural bridge and winding with a shunt sampler
// Assumes: gates are active high, sampler fires every fourth cycle
// Notes: current rates are coarse, only the ordering of levels matters
`timescale 1ns/1ns
module hbd_bridge_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ha,
  input wire logic la,
  input wire logic hb,
  input wire logic lb,
  output logic [11:0] sample,
  output logic valid
);
  logic [11:0] amps;
  logic [1:0] tick;
  wire drive = ha && hb && !la && !lb;
  wire fast = !ha && !hb;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      amps <= 12'h0;
      tick <= 2'h0;
      valid <= 1'b0;
      sample <= 12'h0;
    end else begin
      tick <= tick + 2'h1;
      valid <= tick == 2'h3;
      // slow recirculation bypasses the shunt; stale data is scrambled
      sample <= (tick == 2'h3) ? ((drive || fast) ? amps : 12'h0) : ~sample;
      if (drive) amps <= (amps > 12'hff0) ? 12'hffc : amps + 12'h4;
      else if (fast) amps <= (amps > 12'h10) ? amps - 12'h10 : 12'h0;
      else if (amps != 12'h0) amps <= amps - 12'h1;
    end
  end
endmodule : hbd_bridge_model

/* File: bench/tb_hbd_decay_selector.sv */
// Purpose: self-checking bench of the winding decay selector
// Assumes: pwm period of eight cycles made here, stopped for bus work
// Notes: gate patterns are judged by the bound checker
`timescale 1ns/1ns
module tb_hbd_decay_selector
  import hbd_pkg::*;
;
  logic MCLK = 1'b0, RST_N = 1'b0, PWM_IN = 1'b0, PERIOD_START = 1'b0;
  logic TARGET_STROBE = 1'b0, WR = 1'b0, RD = 1'b0, run = 1'b0, rd_seen = 1'b0;
  logic [11:0] TARGET_CURRENT = 12'h0, SHUNT_SAMPLE;
  logic SHUNT_VALID, CURRENT_VALID, GATE_HIGH_A, GATE_LOW_A, GATE_HIGH_B, GATE_LOW_B;
  logic [HBD_ADDR_W-1:0] ADDR = '0;
  logic [31:0] WDATA = '0, seed = 32'h9fec, RDATA;
  logic [12:0] CURRENT_SIGNED;
  logic [2:0] cnt = 3'h0;
  logic [3:0] duty = 4'h0;
  int fail_count = 0, total_checks = 0;
  logic [31:0] exp_q[$];
  hbd_decay_selector hbd_decay_selector_inst (.MCLK(MCLK), .RST_N(RST_N), .PWM_IN(PWM_IN),
    .PERIOD_START(PERIOD_START), .TARGET_CURRENT(TARGET_CURRENT),
    .TARGET_STROBE(TARGET_STROBE), .SHUNT_SAMPLE(SHUNT_SAMPLE), .SHUNT_VALID(SHUNT_VALID),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .GATE_HIGH_A(GATE_HIGH_A),
    .GATE_LOW_A(GATE_LOW_A), .GATE_HIGH_B(GATE_HIGH_B), .GATE_LOW_B(GATE_LOW_B),
    .CURRENT_SIGNED(CURRENT_SIGNED), .CURRENT_VALID(CURRENT_VALID));
  hbd_bridge_model hbd_bridge_model_inst (.clk(MCLK), .rst_n(RST_N), .ha(GATE_HIGH_A),
    .la(GATE_LOW_A), .hb(GATE_HIGH_B), .lb(GATE_LOW_B), .sample(SHUNT_SAMPLE),
    .valid(SHUNT_VALID));
  initial begin
    forever #5 MCLK = ~MCLK;
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction : lfsr
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic report_and_stop();
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic bus_wr(logic [HBD_ADDR_W-1:0] a, logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(logic [HBD_ADDR_W-1:0] a, logic [31:0] e);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    exp_q.push_back(e);
    @(posedge MCLK);
    RD <= 1'b0;
  endtask : bus_rd
  task automatic step(logic [11:0] t);
    @(posedge MCLK);
    TARGET_CURRENT <= t;
    TARGET_STROBE <= 1'b1;
    @(posedge MCLK);
    TARGET_STROBE <= 1'b0;
  endtask : step
  task automatic periods(int n);
    @(posedge MCLK);
    run <= 1'b1;
    repeat (8 * n) @(posedge MCLK);
    run <= 1'b0;
    repeat (2) @(posedge MCLK);
  endtask : periods
  always @(posedge MCLK) begin
    PERIOD_START <= run && cnt == 3'h7;
    if (run) cnt <= cnt + 3'h1;
    if (run) PWM_IN <= {1'b0, cnt} < duty;
  end
  always @(posedge MCLK) begin
    if (rd_seen) chk("rdata", exp_q.pop_front(), RDATA);
    rd_seen <= RD;
  end
  initial begin
    repeat (20000) @(posedge MCLK);
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge MCLK);
    bus_rd(HBD_REG_POLICY, 32'h0);
    bus_rd(HBD_REG_PRIMARY, 32'h4);
    bus_rd(HBD_REG_SECONDARY, 32'h0);
    bus_rd(HBD_REG_GAIN, 32'h10);
    bus_rd(HBD_REG_STATUS, 32'h24);
    bus_rd(6'h3c, 32'h0);
    // codes 6 and 7 must behave as low fet slow decay
    for (int m = 0; m < 8; m++) begin
      seed = lfsr(seed);
      duty <= 4'(seed[2:0]) + 4'h1;
      bus_wr(HBD_REG_PRIMARY, 32'(m));
      periods(3);
      bus_rd(HBD_REG_STATUS, 32'(m) | (m > 1 ? 32'h20 : 32'h0));
    end
    bus_wr(HBD_REG_SECONDARY, 32'(HBD_REVERSE));
    bus_wr(HBD_REG_PRIMARY, 32'h4);
    bus_wr(HBD_REG_POLICY, 32'h1);
    duty <= 4'h8;
    step(12'd200);
    bus_rd(HBD_REG_REMAIN, 32'h0);
    periods(12);
    step(12'd100);
    bus_rd(HBD_REG_REMAIN, 32'd100);
    periods(1);
    bus_rd(HBD_REG_REMAIN, 32'd99);
    bus_rd(HBD_REG_STATUS, 32'h51);
    bus_wr(HBD_REG_GAIN, 32'h20);
    step(12'd70);
    bus_rd(HBD_REG_REMAIN, 32'd60);
    step(12'd0);
    duty <= 4'h0;
    periods(40);
    step(12'd4000);
    step(12'd3000);
    periods(1);
    bus_rd(HBD_REG_REMAIN, 32'h0);
    bus_rd(HBD_REG_STATUS, 32'h64);
    repeat (2) @(posedge MCLK);
    report_and_stop();
  end
endmodule : tb_hbd_decay_selector
